// ==== rtl/tps_pkg.sv ====
// Constants and field layouts of the timer/counter with its shared prescaler.
// Assumes a register port driven by the core: byte address, write strobe, data.
// Behaviour
// RULE1: Clock source select overrides count pin direction
// RULE2: Sample prescaler output on phases two, four
// RULE3: Unprescaled source: high, low two periods each
// RULE4: Prescaled source period: four periods over ratio
// RULE5: No timer prescaler: input passes straight through
// RULE6: Timer prescaler divides input, symmetric output
// RULE7: Increment only after synchronized output registered
// RULE8: One eight-bit counter, prescaler or postscaler
// RULE9: Prescaler serves timer or watchdog, never both
// RULE10: Option low nibble sets assignment and ratio
// RULE11: Timer count write clears timer-assigned prescaler
// RULE12: Watchdog clear clears watchdog-assigned prescaler
// RULE13: Prescaler count is never readable or loadable
// RULE14: Any reset zeroes the prescaler
// RULE15: Assignment changes apply on option write
// RULE16: Timer-to-watchdog move follows ordered software sequence
// RULE17: Watchdog-to-timer move: clear watchdog, write option
// RULE18: Internal source counts once per instruction cycle
// RULE19: Count write inhibits increments two instruction cycles
// RULE20: Edge select: zero rising, one falling edges
// RULE21: Assignment bit zero gives prescaler to timer
// RULE22: Ratio field n divides by two to n+1
package tps_pkg;

  localparam int         ADDR_W          = 5;
  localparam int         DATA_W          = 8;
  localparam int         PRE_W           = 8;
  localparam int         TRIS_W          = 4;

  // Register file addresses
  localparam logic [4:0] ADDR_TIMER_COUNT = 5'h01;
  localparam logic [4:0] ADDR_CMP_CONTROL = 5'h07;

  // Reset values
  localparam logic [7:0] RST_TIMER_COUNT  = 8'h00;
  localparam logic [7:0] RST_CMP_CONTROL  = 8'hff;
  localparam logic [7:0] RST_OPTION       = 8'hff;
  localparam logic [3:0] RST_PIN_DIR      = 4'hf;
  localparam logic [7:0] RST_PRESCALER    = 8'h00;

  // Comparator control field positions
  localparam int         CMP_RESULT_BIT   = 7;
  localparam int         CMP_OUT_DIS_BIT  = 6;
  localparam int         CMP_TMR_SRC_BIT  = 4;

  // Pin that carries the external count input
  localparam int         EXT_PIN_IDX      = 2;

  // Instruction cycle timing: four phases of one oscillator period
  localparam real        TOSC_NS          = 10.0;
  localparam real        CLK_NS           = 10.0;
  localparam int         PHASES           = 4;
  localparam int         TOSC_CYC         = int'(TOSC_NS / CLK_NS);
  localparam logic [1:0] PH_TWO           = 2'h1;
  localparam logic [1:0] PH_FOUR          = 2'h3;
  localparam logic [1:0] INHIBIT_CYCLES   = 2'h2;

  // Option register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       wake_on_change_n;
    logic       pullup_n;
    logic       clk_src_sel;
    logic       edge_sel;
    logic       assign_wdt;
    logic [2:0] ratio;
  } tps_option_s;

  // Register port carrier
  typedef struct packed {
    logic [4:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } tps_regreq_s;

endpackage

// ==== rtl/tps_timer.sv ====
// Eight-bit timer/counter with the shared prescaler/postscaler.
// Assumes one core clock; phases are derived inside from ref_clk_i.
`timescale 1ns/1ps
`default_nettype none

module tps_timer #(
  parameter int PRE_W = tps_pkg::PRE_W
) (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  // Core register port
  input  wire tps_pkg::tps_regreq_s reg_req_i,
  output logic [7:0]               reg_rdata_o,
  // Special writes and instructions
  input  wire logic                option_wr_i,
  input  wire logic [7:0]          option_wdata_i,
  input  wire logic                pin_dir_wr_i,
  input  wire logic [3:0]          pin_dir_wdata_i,
  input  wire logic                watchdog_clear_instr_i,
  input  wire logic                watchdog_tick_i,
  // External count sources
  input  wire logic                ext_count_input_i,
  input  wire logic                comparator_result_i,
  // Outputs
  output logic [3:0]               pin_direction_o,
  output logic                     watchdog_post_tick_o,
  output logic [1:0]               phase_o
);

  // Phase counter: Q1..Q4 as 0..3
  logic [1:0] phase_reg;
  wire        phase_two  = (phase_reg == tps_pkg::PH_TWO);
  wire        phase_four = (phase_reg == tps_pkg::PH_FOUR);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Input synchronisers, three stages, change taken when the last two stages agree
  logic [1:0] raw_in;
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic [1:0] clean_reg;
  assign raw_in = {comparator_result_i, ext_count_input_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_reg[gi]    <= 1'b0;
          s2_reg[gi]    <= 1'b0;
          s3_reg[gi]    <= 1'b0;
          clean_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= raw_in[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            clean_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  wire pin_lvl = clean_reg[0];
  wire cmp_lvl = clean_reg[1];

  // Registers
  logic [7:0]          timer_count_reg;
  logic [7:0]          timer_count_next;
  logic [7:0]          cmp_ctrl_reg;
  tps_pkg::tps_option_s opt_reg;
  logic [3:0]          pin_dir_reg;
  logic [PRE_W-1:0]    pre_reg;
  logic [PRE_W-1:0]    pre_next;
  logic [1:0]          inhibit_reg;
  logic                samp_reg;
  logic                samp_prev_reg;
  logic                inc_reg;
  logic                wdt_prev_reg;

  wire wr_count = reg_req_i.wr && (reg_req_i.addr == tps_pkg::ADDR_TIMER_COUNT);
  wire wr_cmp   = reg_req_i.wr && (reg_req_i.addr == tps_pkg::ADDR_CMP_CONTROL);

  // Source selection
  wire on_timer   = !opt_reg.assign_wdt; // RULE9 RULE21
  wire ext_mode   = opt_reg.clk_src_sel;
  wire pin_select = cmp_ctrl_reg[tps_pkg::CMP_TMR_SRC_BIT] &&
                    cmp_ctrl_reg[tps_pkg::CMP_OUT_DIS_BIT];
  wire ext_lvl    = (pin_select ? pin_lvl : cmp_lvl) ^ opt_reg.edge_sel; // RULE20

  // Edge of the chosen source, as seen by the ripple stage
  logic ext_prev_reg;
  wire  ext_rise  = ext_lvl && !ext_prev_reg;
  wire  int_event = phase_four;
  wire  src_event = ext_mode ? ext_rise : int_event;

  // Prescaler advance and clear
  wire  pre_clear = (on_timer && wr_count) ||              // RULE11
                    (!on_timer && watchdog_clear_instr_i); // RULE12
  wire  pre_adv   = on_timer ? src_event : watchdog_tick_i; // RULE9

  always_comb begin
    pre_next = pre_reg;
    if (pre_clear) begin
      pre_next = '0;
    end else if (pre_adv) begin
      pre_next = pre_reg + {{(PRE_W-1){1'b0}}, 1'b1}; // RULE8
    end
  end

  // Prescaler output: divide by 2^(n+1), symmetric square wave
  wire pre_bit = pre_reg[opt_reg.ratio]; // RULE6 RULE22
  wire pre_out = ext_mode ? (on_timer ? pre_bit : ext_lvl) // RULE5
                          : pre_bit;

  // Sample on phase two and four, edge registered before counting
  wire samp_rise = samp_reg && !samp_prev_reg;
  wire direct_inc = !ext_mode && !on_timer && int_event; // RULE18
  wire count_inc  = ext_mode || on_timer ? inc_reg : direct_inc;

  always_comb begin
    timer_count_next = timer_count_reg;
    if (wr_count) begin
      timer_count_next = reg_req_i.wdata;
    end else if (count_inc && (inhibit_reg == 2'h0)) begin // RULE19
      timer_count_next = timer_count_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_reg       <= tps_pkg::RST_PRESCALER; // RULE14
      // High after reset: a source already high gives no false edge
      ext_prev_reg  <= 1'b1;
      samp_reg      <= 1'b1;
      samp_prev_reg <= 1'b1;
      inc_reg       <= 1'b0;
    end else begin
      pre_reg      <= pre_next;
      ext_prev_reg <= ext_lvl;
      if (phase_two || phase_four) begin
        samp_reg      <= pre_out; // RULE2
        samp_prev_reg <= samp_reg;
      end
      inc_reg <= samp_rise && (phase_two || phase_four); // RULE7
    end
  end

  // Timer count and its write inhibit
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_count_reg <= tps_pkg::RST_TIMER_COUNT;
      inhibit_reg     <= 2'h0;
    end else begin
      timer_count_reg <= timer_count_next;
      if (wr_count) begin
        inhibit_reg <= tps_pkg::INHIBIT_CYCLES; // RULE19
      end else if (phase_four && inhibit_reg != 2'h0) begin
        inhibit_reg <= inhibit_reg - 2'h1;
      end
    end
  end

  // Software-visible configuration; option applies on the same edge
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_ctrl_reg <= tps_pkg::RST_CMP_CONTROL;
      opt_reg      <= tps_pkg::RST_OPTION;
      pin_dir_reg  <= tps_pkg::RST_PIN_DIR;
    end else begin
      if (wr_cmp) begin
        cmp_ctrl_reg <= reg_req_i.wdata;
      end
      if (option_wr_i) begin
        opt_reg <= option_wdata_i; // RULE10 RULE15
      end
      if (pin_dir_wr_i) begin
        pin_dir_reg <= pin_dir_wdata_i;
      end
    end
  end

  // Read data; prescaler has no address, so it cannot be read
  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00; // RULE13
    case (reg_req_i.addr)
      tps_pkg::ADDR_TIMER_COUNT: rdata_next = timer_count_reg;
      tps_pkg::ADDR_CMP_CONTROL: rdata_next = {cmp_lvl, cmp_ctrl_reg[6:0]};
      default:                   rdata_next = 8'h00;
    endcase
  end

  // Watchdog postscaler: ratio n gives 1:2^n, 1:1 passes the tick
  // Without the prescaler the watchdog still times out, at 1:1
  wire wdt_direct = on_timer || (opt_reg.ratio == 3'h0); // RULE9
  wire wdt_bit    = wdt_direct ? watchdog_tick_i
                               : pre_reg[opt_reg.ratio - 3'h1];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o          <= 8'h00;
      wdt_prev_reg         <= 1'b0;
      watchdog_post_tick_o <= 1'b0;
      pin_direction_o      <= tps_pkg::RST_PIN_DIR;
    end else begin
      reg_rdata_o  <= rdata_next;
      wdt_prev_reg <= wdt_bit;
      watchdog_post_tick_o <= wdt_bit && !wdt_prev_reg; // RULE9
      pin_direction_o <= pin_dir_reg;
      if (ext_mode) begin
        pin_direction_o[tps_pkg::EXT_PIN_IDX] <= 1'b1; // RULE1
      end
    end
  end

  assign phase_o = phase_reg;

endmodule

`default_nettype wire

// ==== tb/tps_timer_monitor.sv ====
// Port-level checker for the timer/counter and shared prescaler.
// Assumes one clock; bound to every tps_timer instance.
`timescale 1ns/1ps
`default_nettype none
module tps_timer_monitor #(
  parameter int PRE_W = tps_pkg::PRE_W
) (
  // Clock, reset, register port
  input wire logic                 ref_clk_i,
  input wire logic                 rst_i,
  input wire tps_pkg::tps_regreq_s reg_req_i,
  input wire logic [7:0]           reg_rdata_o,
  // Strobes and sources
  input wire logic                 option_wr_i,
  input wire logic [7:0]           option_wdata_i,
  input wire logic                 pin_dir_wr_i,
  input wire logic [3:0]           pin_dir_wdata_i,
  input wire logic                 watchdog_clear_instr_i,
  input wire logic                 watchdog_tick_i,
  input wire logic                 ext_count_input_i,
  input wire logic                 comparator_result_i,
  // Outputs
  input wire logic [3:0]           pin_direction_o,
  input wire logic                 watchdog_post_tick_o,
  input wire logic [1:0]           phase_o
);
  logic       psa_q;
  logic [7:0] rd_q;
  logic [1:0] rd01_q;
  logic [2:0] wr01_q;
  wire        cnt_wr = reg_req_i.wr && (reg_req_i.addr == tps_pkg::ADDR_TIMER_COUNT);
  // Count change seen only with address held and no recent write
  wire        chg    = (rd_q != reg_rdata_o) && (&rd01_q) && (wr01_q == 3'h0);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      psa_q  <= 1'b1;
      rd_q   <= 8'h00;
      rd01_q <= 2'h0;
      wr01_q <= 3'h0;
    end else begin
      if (option_wr_i) begin
        psa_q <= option_wdata_i[3];
      end
      rd_q   <= reg_rdata_o;
      rd01_q <= {rd01_q[0], reg_req_i.addr == tps_pkg::ADDR_TIMER_COUNT};
      wr01_q <= {wr01_q[1:0], cnt_wr};
    end
  end
  AST_PIN_OVERRIDE: assert property (option_wr_i && option_wdata_i[5] |->
    ##[1:2] pin_direction_o[2])
    else $error("pin direction not overridden");
  AST_PHASE_STEP: assert property (!$past(rst_i) |->
    phase_o == $past(phase_o) + 2'h1)
    else $error("phase did not step");
  AST_WR_LOAD: assert property (cnt_wr ##1
    (reg_req_i.addr == tps_pkg::ADDR_TIMER_COUNT) |=> reg_rdata_o == $past(reg_req_i.wdata, 2))
    else $error("count write not held");
  AST_INC_ONE: assert property (chg |-> reg_rdata_o == rd_q + 8'h01)
    else $error("count moved by other than one");
  AST_INC_GAP: assert property (chg |=> !chg [*3])
    else $error("count moved twice in one cycle");
  AST_NO_PRE_READ: assert property (reg_req_i.addr != 5'h01 &&
    reg_req_i.addr != 5'h07 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_WDT_BYPASS: assert property (!$past(psa_q) |->
    watchdog_post_tick_o == $past(watchdog_tick_i))
    else $error("watchdog tick not passed through");
  AST_POST_CAUSE: assert property (watchdog_post_tick_o |->
    $past(watchdog_tick_i) || $past(watchdog_tick_i, 2))
    else $error("post tick without tick");
  cover property (chg);
  cover property (cnt_wr);
  cover property (watchdog_post_tick_o && psa_q);
endmodule
bind tps_timer tps_timer_monitor #(.PRE_W(PRE_W)) mon_u (.ref_clk_i, .rst_i, .reg_req_i,
  .reg_rdata_o, .option_wr_i, .option_wdata_i, .pin_dir_wr_i, .pin_dir_wdata_i,
  .watchdog_clear_instr_i, .watchdog_tick_i, .ext_count_input_i, .comparator_result_i,
  .pin_direction_o, .watchdog_post_tick_o, .phase_o);
`default_nettype wire

// ==== tb/tps_src_model.sv ====
// Far-side count source: pin level and comparator level.
// Assumes the bench calls burst from its own thread.
`timescale 1ns/1ps
`default_nettype none
module tps_src_model (
  input  wire logic ref_clk_i,
  output logic      ext_o,
  output logic      cmp_o
);
  initial begin
    ext_o = 1'b0;
    cmp_o = 1'b0;
  end
  // Each level held half clocks, never under two
  task automatic burst(input int n, input int half, input logic on_cmp);
    repeat (n) begin
      repeat (half) @(posedge ref_clk_i);
      if (on_cmp) begin
        cmp_o <= ~cmp_o;
      end else begin
        ext_o <= ~ext_o;
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_timer_prescaler_sync.sv ====
// Self-checking bench for the timer/counter with shared prescaler.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_timer_prescaler_sync;
  logic                 ref_clk_i = 1'b0;
  logic                 rst_i     = 1'b1;
  tps_pkg::tps_regreq_s req       = '0;
  logic                 opt_wr    = 1'b0;
  logic [7:0]           opt_d     = 8'h00;
  logic                 pd_wr     = 1'b0;
  logic [3:0]           pd_d      = 4'h0;
  logic                 wclr      = 1'b0;
  logic                 wtick     = 1'b0;
  logic                 ext_lvl;
  logic                 cmp_lvl;
  logic [7:0]           rdata;
  logic [3:0]           pin_dir;
  logic                 post;
  logic [1:0]           phase;
  logic [7:0]           v;
  int                   num_errors = 0;
  int                   n_checks   = 0;
  int                   n_post     = 0;
  int                   cycles     = 0;

  tps_timer dut_u (.ref_clk_i, .rst_i, .reg_req_i(req), .reg_rdata_o(rdata),
    .option_wr_i(opt_wr), .option_wdata_i(opt_d), .pin_dir_wr_i(pd_wr), .pin_dir_wdata_i(pd_d),
    .watchdog_clear_instr_i(wclr), .watchdog_tick_i(wtick), .ext_count_input_i(ext_lvl),
    .comparator_result_i(cmp_lvl), .pin_direction_o(pin_dir), .watchdog_post_tick_o(post),
    .phase_o(phase));
  tps_src_model src_u (.ref_clk_i, .ext_o(ext_lvl), .cmp_o(cmp_lvl));

  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (post === 1'b1) n_post++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge ref_clk_i);
    req.wr <= 1'b0;
  endtask
  task automatic opt(input logic [7:0] d);
    @(posedge ref_clk_i);
    opt_wr <= 1'b1;
    opt_d <= d;
    @(posedge ref_clk_i);
    opt_wr <= 1'b0;
  endtask
  task automatic clr();
    @(posedge ref_clk_i);
    wclr <= 1'b1;
    @(posedge ref_clk_i);
    wclr <= 1'b0;
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge ref_clk_i);
      wtick <= 1'b1;
      @(posedge ref_clk_i);
      wtick <= 1'b0;
    end
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge ref_clk_i);
    req.addr <= a;
    repeat (2) @(posedge ref_clk_i);
    #1 v = rdata;
  endtask
  task automatic chk(input logic [7:0] lo, input logic [7:0] hi);
    n_checks++;
    if ((^v === 1'bx) || v < lo || v > hi) begin
      num_errors++;
      $display("ERROR %0t got %h want %h..%h", $time, v, lo, hi);
    end
  endtask
  // Source, watchdog clear first, mode, settle, then zero the count
  task automatic setup(input logic [7:0] cmp, input logic [7:0] o);
    wr(5'h07, cmp);
    clr();
    opt(o);
    repeat (8) @(posedge ref_clk_i);
    wr(5'h01, 8'h00);
  endtask

  task automatic t_reset();
    rd(5'h01);
    chk(8'h00, 8'h00);
    rd(5'h03);
    chk(8'h00, 8'h00);
    @(posedge ref_clk_i);
    pd_wr <= 1'b1;
    @(posedge ref_clk_i);
    pd_wr <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    v = {4'h0, pin_dir};
    chk(8'h04, 8'h04);
    $display("reset test done");
  endtask
  task automatic t_internal();
    opt(8'hdf);
    repeat (3) @(posedge ref_clk_i);
    v = {4'h0, pin_dir};
    chk(8'h00, 8'h00);
    wr(5'h01, 8'h10);
    rd(5'h01);
    chk(8'h10, 8'h10);
    repeat (40) @(posedge ref_clk_i);
    rd(5'h01);
    chk(8'h19, 8'h1a);
    $display("internal test done");
  endtask
  task automatic t_prescale();
    for (int n = 0; n < 3; n++) begin
      setup(8'h7f, 8'hd0 | 8'(n));
      repeat (128) @(posedge ref_clk_i);
      rd(5'h01);
      chk(8'(32 >> (n + 1)) - 8'h02, 8'(32 >> (n + 1)));
    end
    $display("prescale test done");
  endtask
  task automatic t_external();
    setup(8'h7f, 8'hf8);
    src_u.burst(7, 3, 1'b0);
    repeat (12) @(posedge ref_clk_i);
    rd(5'h01);
    chk(8'h03, 8'h03);
    setup(8'h7f, 8'he8);
    src_u.burst(5, 3, 1'b0);
    repeat (12) @(posedge ref_clk_i);
    rd(5'h01);
    chk(8'h02, 8'h02);
    setup(8'h6f, 8'he8);
    src_u.burst(6, 3, 1'b1);
    repeat (12) @(posedge ref_clk_i);
    rd(5'h01);
    chk(8'h03, 8'h03);
    setup(8'h7f, 8'he0);
    src_u.burst(16, 2, 1'b0);
    repeat (12) @(posedge ref_clk_i);
    rd(5'h01);
    chk(8'h04, 8'h04);
    $display("external test done");
  endtask
  task automatic t_watchdog();
    clr();
    wr(5'h01, 8'h00);
    opt(8'hfa);
    n_post = 0;
    ticks(3);
    v = 8'(n_post);
    chk(8'h01, 8'h01);
    clr();
    n_post = 0;
    ticks(2);
    v = 8'(n_post);
    chk(8'h01, 8'h01);
    ticks(5);
    v = 8'(n_post);
    chk(8'h02, 8'h02);
    clr();
    opt(8'hf2);
    n_post = 0;
    ticks(8);
    v = 8'(n_post);
    chk(8'h08, 8'h08);
    $display("watchdog test done");
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_internal();
    t_prescale();
    t_external();
    t_watchdog();
    wrap_up();
  end
endmodule
`default_nettype wire
